// ===== bench/obcd_monitor.sv
// Checker of the divider's pin relations.
// Assumes binding to every instance of the divider.
`timescale 1ns/100ps
`default_nettype none
module obcd_monitor
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow_setting_write,
    input wire logic slow_setting_value,
    input wire logic stop_enter,
    input wire logic clock_out_select,
    input wire logic port_c_line_two_data,
    input wire logic slow_setting_bit,
    input wire logic bus_enable,
    input wire logic bus_clock_level,
    input wire logic can_module_enable,
    input wire logic port_c_line_two
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_can_gap: assert property (can_module_enable |=> !can_module_enable)
        else $error("can enable too close");
    a_can_runs: assert property (!can_module_enable |=> can_module_enable)
        else $error("can enable missing");
    a_stop_clears: assert property (stop_enter |=> !slow_setting_bit)
        else $error("stop left slow bit set");
    a_write_loads: assert property (slow_setting_write && !stop_enter |=>
        slow_setting_bit == $past(slow_setting_value)) else $error("slow write lost");
    a_slow_holds: assert property (!slow_setting_write && !stop_enter |=>
        $stable(slow_setting_bit)) else $error("slow bit moved");
    a_bus_gap: assert property (bus_enable |=> !bus_enable)
        else $error("bus enable too close");
    a_bus_within: assert property (bus_enable |-> ##[2:160] bus_enable)
        else $error("bus enable late");
    a_level_start: assert property ($rose(bus_clock_level) |-> bus_enable)
        else $error("bus level rose off boundary");
    a_enable_rise: assert property (bus_enable |-> $rose(bus_clock_level))
        else $error("bus period began without a rising level");
    a_pin_route: assert property (clock_out_select [*2] |-> port_c_line_two ==
        bus_clock_level || port_c_line_two == $past(bus_clock_level))
        else $error("pin not showing bus clock");
    a_pin_data: assert property (!clock_out_select |=>
        port_c_line_two == $past(port_c_line_two_data)) else $error("pin lost port data");
endmodule : obcd_monitor
bind obcd_clock_divider obcd_monitor obcd_monitor_inst (.*);
`default_nettype wire

// ===== bench/obcd_osc_model.sv
// Oscillator source standing at the divider's clock pin.
// Assumes a steady 25 MHz source; the divider sees only its edges.
`timescale 1ns/100ps
`default_nettype none
module obcd_osc_model
(
    output logic clock
);
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
endmodule : obcd_osc_model
`default_nettype wire

// ===== bench/tb_oscillator_bus_clock_divider.sv
// Self-checking bench of the divider built once for each predivider ratio.
// Assumes the oscillator model supplies the clock.
`timescale 1ns/100ps
`default_nettype none
module tb_oscillator_bus_clock_divider;
    // Bus periods of the four builds at normal speed, in oscillator clocks.
    localparam int RATIO_OF [4] = '{2, 4, 8, 10};
    logic clock;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic val = 1'b0;
    logic stp = 1'b0;
    logic sel = 1'b0;
    logic pd = 1'b0;
    logic [3:0] sb;
    logic [3:0] be;
    logic [3:0] bl;
    logic [3:0] ce;
    logic [3:0] pc;
    logic [7:0] n;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;
    obcd_osc_model obcd_osc_model_inst
    (
        .clock(clock)
    );
    for (genvar g = 0; g < 4; g++)
    begin : g_build
        obcd_clock_divider #(.RATIO(obcd_pkg::obcd_ratio_e'(g))) obcd_clock_divider_inst
        (
            .clock(clock),
            .rst_n(rst_n),
            .slow_setting_write(wr),
            .slow_setting_value(val),
            .stop_enter(stp),
            .clock_out_select(sel),
            .port_c_line_two_data(pd),
            .slow_setting_bit(sb[g]),
            .bus_enable(be[g]),
            .bus_clock_level(bl[g]),
            .can_module_enable(ce[g]),
            .port_c_line_two(pc[g])
        );
    end
    task chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: level %b want %b", $time, got, exp);
        end
    endtask : chk_bit
    task chk_count(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: period %0d want %0d", $time, got, exp);
        end
    endtask : chk_count
    // Index 0 to 3 picks a build's bus enable; index 4 the CAN enable of the last build.
    function automatic logic pulse_of(input int idx);
        return (idx == 4) ? ce[3] : be[idx[1:0]];
    endfunction : pulse_of
    task period(input int idx);
        do @(negedge clock); while (pulse_of(idx) !== 1'b1);
        n = 8'h00;
        do
        begin
            @(negedge clock);
            n++;
        end while (pulse_of(idx) !== 1'b1);
    endtask : period
    task t_normal;
        chk_bit(sb[3], 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            period(i);
            chk_count(n, 8'(RATIO_OF[i]));
        end
        period(4);
        chk_count(n, 8'h02);
    endtask : t_normal
    task t_slow;
        wr = 1'b1;
        val = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        chk_bit(sb[3], 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            period(i);
            chk_count(n, 8'(16 * RATIO_OF[i]));
        end
        period(4);
        chk_count(n, 8'h02);
    endtask : t_slow
    // The slow bus clock of the ratio-ten build is high for 80 clocks, then low for 80.
    task t_pin;
        pd = 1'b1;
        repeat (2) @(negedge clock);
        chk_bit(pc[3], 1'b1);
        sel = 1'b1;
        period(3);
        chk_bit(pc[3], 1'b1);
        repeat (79) @(negedge clock);
        chk_bit(bl[3], 1'b1);
        chk_bit(pc[3], 1'b1);
        @(negedge clock);
        chk_bit(bl[3], 1'b0);
        chk_bit(pc[3], 1'b0);
        sel = 1'b0;
        repeat (2) @(negedge clock);
        chk_bit(pc[3], 1'b1);
        pd = 1'b0;
    endtask : t_pin
    task t_stop;
        wr = 1'b1;
        val = 1'b1;
        stp = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        stp = 1'b0;
        chk_bit(sb[3], 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            period(i);
            chk_count(n, 8'(RATIO_OF[i]));
        end
    endtask : t_stop
    task t_reset;
        wr = 1'b1;
        val = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        chk_bit(sb[3], 1'b1);
        rst_n = 1'b0;
        @(negedge clock);
        chk_bit(sb[3], 1'b0);
        chk_bit(ce[3], 1'b0);
        repeat (3) @(negedge clock);
        rst_n = 1'b1;
        period(3);
        chk_count(n, 8'h0A);
    endtask : t_reset
    task end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    always @(posedge clock)
    begin
        cycles++;
        if (cycles > 4000)
        begin
            mismatches++;
            end_sim();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        t_normal();
        t_slow();
        t_pin();
        t_stop();
        t_reset();
        end_sim();
    end
endmodule : tb_oscillator_bus_clock_divider
`default_nettype wire

// ===== hdl/obcd_clock_divider.sv
// Oscillator to bus clock divider with slow setting and CAN clock.
// Assumes clock is the oscillator itself; bus_enable and can_module_enable are one-cycle enables.
`timescale 1ns/100ps
`default_nettype none
`include "obcd_defines.svh"
module obcd_clock_divider
#(
    parameter obcd_pkg::obcd_ratio_e RATIO = obcd_pkg::OBCD_DIV2
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow_setting_write,
    input wire logic slow_setting_value,
    input wire logic stop_enter,
    input wire logic clock_out_select,
    input wire logic port_c_line_two_data,
    output logic slow_setting_bit,
    output logic bus_enable,
    output logic bus_clock_level,
    output logic can_module_enable,
    output logic port_c_line_two
);
    obcd_tick_if pre_if ();

    logic next_slow_bit;
    logic active_slow;
    logic next_active_slow;

    logic [4:0] half_count;
    logic [4:0] next_half_count;
    logic [4:0] half_last;
    logic [4:0] half_fall;

    logic bus_level;
    logic next_bus_level;
    logic next_bus_enable;

    logic can_phase;
    logic next_can_phase;
    logic next_can_enable;

    logic next_pin;

    // Fixed ratio
    // The predivider ticks at half the normal-speed bus period, so that the bus clock level can
    // fall in the middle of a period even at the fastest ratio.
    always_comb
    begin
        unique case (RATIO)
            obcd_pkg::OBCD_DIV2: pre_if.ratio = `OBCD_HALF_DIV2;
            obcd_pkg::OBCD_DIV4: pre_if.ratio = `OBCD_HALF_DIV4;
            obcd_pkg::OBCD_DIV8: pre_if.ratio = `OBCD_HALF_DIV8;
            obcd_pkg::OBCD_DIV10: pre_if.ratio = `OBCD_HALF_DIV10;
        endcase
    end

    obcd_pulse_div u_pre
    (
        .clock(clock),
        .rst_n(rst_n),
        .enable(1'b1),
        .tif(pre_if)
    );

    // Stop clears slow
    // A stop in the same cycle as a write wins, so stop mode never resumes slowly.
    always_comb
    begin
        next_slow_bit = slow_setting_bit;
        if (stop_enter)
        begin
            next_slow_bit = 1'b0;
        end
        else if (slow_setting_write)
        begin
            next_slow_bit = slow_setting_value;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            slow_setting_bit <= `OBCD_SLOW_RESET;
        end
        else
        begin
            slow_setting_bit <= next_slow_bit;
        end
    end

    // Sixteen-fold bus period
    // A bus period is two half ticks at normal speed and thirty-two when slow.
    always_comb
    begin
        if (active_slow)
        begin
            half_last = `OBCD_HALF_LAST_SLOW;
            half_fall = `OBCD_HALF_FALL_SLOW;
        end
        else
        begin
            half_last = `OBCD_HALF_LAST_NORMAL;
            half_fall = `OBCD_HALF_FALL_NORMAL;
        end
    end

    always_comb
    begin
        next_half_count = half_count;
        next_active_slow = active_slow;
        next_bus_level = bus_level;
        next_bus_enable = 1'b0;
        if (pre_if.tick)
        begin
            if (half_count == half_last)
            begin
                // Rate switch at boundary
                // Taking the new rate only where a period starts keeps every phase whole.
                next_half_count = 5'h00;
                next_active_slow = slow_setting_bit;
                next_bus_enable = 1'b1;
                next_bus_level = 1'b1;
            end
            else
            begin
                next_half_count = half_count + 5'h01;
                if (half_count == half_fall)
                begin
                    next_bus_level = 1'b0;
                end
            end
        end
    end

    // Full oscillator rate
    // Everything runs on the oscillator clock with enables, so no stage ever needs
    // a clock faster than the input pin.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active_slow <= `OBCD_SLOW_RESET;
            half_count <= 5'h00;
            bus_enable <= 1'b0;
            bus_level <= 1'b0;
        end
        else
        begin
            active_slow <= next_active_slow;
            half_count <= next_half_count;
            bus_enable <= next_bus_enable;
            bus_level <= next_bus_level;
        end
    end

    always_comb
    begin
        next_can_phase = ~can_phase;
        next_can_enable = can_phase;
    end

    // Starting the phase high puts the first CAN enable on the first edge after reset.
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            can_phase <= `OBCD_CAN_RESET;
            can_module_enable <= 1'b0;
        end
        else
        begin
            can_phase <= next_can_phase;
            can_module_enable <= next_can_enable;
        end
    end

    // Clock out on pin
    // The pin follows the next level, so it moves on the same edge as the bus level.
    always_comb
    begin
        if (clock_out_select)
        begin
            next_pin = next_bus_level;
        end
        else
        begin
            next_pin = port_c_line_two_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_c_line_two <= 1'b0;
        end
        else
        begin
            port_c_line_two <= next_pin;
        end
    end

    assign bus_clock_level = bus_level;
endmodule : obcd_clock_divider
`default_nettype wire

// ===== hdl/obcd_pulse_div.sv
// Enable-pulse divider: one tick every ratio input clocks.
// Assumes ratio is at least 1 and stable between ticks.
`timescale 1ns/100ps
`default_nettype none
`include "obcd_defines.svh"
module obcd_pulse_div
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic enable,
    obcd_tick_if.divider tif
);
    logic [7:0] count;
    logic [7:0] next_count;
    always_comb
    begin
        next_count = count;
        tif.tick = 1'b0;
        if (enable)
        begin
            if (count >= tif.ratio - 8'h01)
            begin
                next_count = 8'h00;
                tif.tick = 1'b1;
            end
            else
            begin
                next_count = count + 8'h01;
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            count <= 8'h00;
        else
            count <= next_count;
    end
endmodule : obcd_pulse_div
`default_nettype wire

// ===== pkg/obcd_defines.svh
// Constants for the oscillator-to-bus clock divider.
// Assumes inclusion by bare name from design files.
`ifndef OBCD_DEFINES_SVH
`define OBCD_DEFINES_SVH
`define OBCD_SLOW_FACTOR 16
`define OBCD_CAN_RATIO 2
`define OBCD_CNT_W 8
`define OBCD_SLOW_W 4
`define OBCD_SLOW_RESET 1'b0
`define OBCD_CAN_RESET 1'b1
`define OBCD_HALF_DIV2 8'h01
`define OBCD_HALF_DIV4 8'h02
`define OBCD_HALF_DIV8 8'h04
`define OBCD_HALF_DIV10 8'h05
`define OBCD_HALF_LAST_NORMAL 5'h01
`define OBCD_HALF_LAST_SLOW 5'h1F
`define OBCD_HALF_FALL_NORMAL 5'h00
`define OBCD_HALF_FALL_SLOW 5'h0F
`endif

// ===== pkg/obcd_pkg.sv
// Types for the oscillator-to-bus clock divider.
// Assumes nothing of its surroundings.
package obcd_pkg;
    typedef enum logic [1:0] {OBCD_DIV2, OBCD_DIV4, OBCD_DIV8, OBCD_DIV10} obcd_ratio_e;
endpackage : obcd_pkg

// ===== pkg/obcd_tick_if.sv
// Carrier between the top and the pulse divider.
// Assumes one shared clock domain.
`timescale 1ns/100ps
`default_nettype none
interface obcd_tick_if;
    logic [7:0] ratio;
    logic tick;
    modport owner (output ratio, input tick);
    modport divider (input ratio, output tick);
endinterface : obcd_tick_if
`default_nettype wire
